// *** lad_local_io_address_decoder.sv ***
/*
  Address decoder and access-size checker for the slave I/O window.
  Takes one slave cycle at a time, selects at most one local device, waits for its
  ready, then acknowledges; illegal cycles get an error acknowledge.
  Assumes a single clock (the slave bus clock) and synchronous inputs from
  the bus master and local devices on that clock.
*/
`timescale 1ns/1ns
`default_nettype none

module lad_local_io_address_decoder (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Slave cycle from the bus master
  input wire logic sel_i,
  input wire logic as_i,
  input wire logic [31:0] addr_i,
  input wire logic [2:0] size_i,
  input wire logic rd_i,
  // Acknowledge to the bus master
  output logic [1:0] ack_o,
  output logic err_o,
  // Local device side
  output logic [lad_pkg::SEL_W-1:0] dev_sel_o,
  output logic [lad_pkg::FREG_W-1:0] floppy_reg_o,
  output logic [lad_pkg::SREG_W-1:0] serial_reg_o,
  output logic [31:0] dev_addr_o,
  output logic dev_rd_o,
  output logic dev_wr_o,
  input wire logic dev_ready_i
);
  import lad_pkg::*;

  // ----------------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------------
  function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo,
                                    input logic [31:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic [1:0] ack_for(input logic [2:0] sz);
    unique case (sz)
      SIZE_BYTE: ack_for = ACK_BYTE;
      SIZE_HALF: ack_for = ACK_HALF;
      default: ack_for = ACK_WORD;
    endcase
  endfunction

  lad_state_e state_reg;
  logic [SEL_W-1:0] sel_next;
  logic [FREG_W-1:0] freg_next;
  logic [SREG_W-1:0] sreg_next;
  logic any_size;
  logic byte_only;
  logic ok_next;
  logic start;
  logic [1:0] ack_reg;
  logic err_reg;

  assign start = sel_i && as_i && (state_reg == LAD_IDLE);
  assign byte_only = (size_i == SIZE_BYTE);
  assign any_size = (size_i == SIZE_BYTE) || (size_i == SIZE_HALF) || (size_i == SIZE_WORD);

  // ----------------------------------------------------------------------
  // Region and register decode
  // ----------------------------------------------------------------------
  always_comb begin
    sel_next = '0;
    freg_next = '0;
    sreg_next = '0;
    ok_next = 1'b0;
    if (in_range(addr_i, FLASH_LO, FLASH_HI)) begin
      ok_next = any_size;
      sel_next[SEL_FLASH] = ok_next;
    end else if (in_range(addr_i, SERIAL_LO, SERIAL_HI)) begin
      ok_next = byte_only;
      sel_next[SEL_SERIAL] = ok_next;
      sreg_next[0] = ok_next && (addr_i == POINTER_CTRL_PORT);
      sreg_next[1] = ok_next && (addr_i == POINTER_DATA_PORT);
      sreg_next[2] = ok_next && (addr_i == KEYS_CTRL_PORT);
      sreg_next[3] = ok_next && (addr_i == KEYS_DATA_PORT);
      sreg_next[4] = ok_next && (addr_i == SERIAL_TWO_CTRL);
      sreg_next[5] = ok_next && (addr_i == SERIAL_TWO_DATA);
      sreg_next[6] = ok_next && (addr_i == SERIAL_ONE_CTRL);
      sreg_next[7] = ok_next && (addr_i == SERIAL_ONE_DATA);
    end else if (in_range(addr_i, CLKNV_LO, CLKNV_HI)) begin
      ok_next = any_size;
      sel_next[SEL_CLKNV] = ok_next;
    end else if (in_range(addr_i, PROG_LO, PROG_HI)) begin
      ok_next = byte_only;
      sel_next[SEL_PROG] = ok_next;
    end else if (in_range(addr_i, EXTRA_LO, EXTRA_HI)) begin
      ok_next = byte_only;
      sel_next[SEL_EXTRA] = ok_next;
    end else if (in_range(addr_i, FLOPPY_LO, FLOPPY_HI)) begin
      ok_next = byte_only;
      sel_next[SEL_FLOPPY] = ok_next;
      freg_next[FREG_OUT_CTRL] = ok_next && (addr_i == FLOPPY_OUT_CTRL);
      freg_next[FREG_MAIN_STATE] = ok_next && (addr_i == FLOPPY_STATE_RATE) && rd_i;
      freg_next[FREG_RATE_SELECT] = ok_next && (addr_i == FLOPPY_STATE_RATE) && !rd_i;
      freg_next[FREG_DATA_QUEUE] = ok_next && (addr_i == FLOPPY_DATA_QUEUE);
      freg_next[FREG_INPUT_STATE] = ok_next && (addr_i == FLOPPY_INPUT_CONFIG) && rd_i;
      freg_next[FREG_CONFIG_CTRL] = ok_next && (addr_i == FLOPPY_INPUT_CONFIG) && !rd_i;
      // Test-mode select is passed on as decoded; software keeps away.
      freg_next[FREG_TEST_SELECT] = ok_next && (addr_i == FLOPPY_TEST_SELECT);
    end else if (in_range(addr_i, RSVD_LO, RSVD_HI)) begin
      ok_next = 1'b0;
    end else if (addr_i == CONFIG_ADDR) begin
      ok_next = byte_only;
      sel_next[SEL_CONFIG] = ok_next;
    end else if (addr_i == SOFT_POWERDOWN_CTRL) begin
      ok_next = byte_only;
      sel_next[SEL_AUX2] = ok_next;
    end else if (in_range(addr_i, AUX_LO, AUX_HI)) begin
      ok_next = byte_only;
      sel_next[SEL_AUX1] = ok_next && (addr_i == MISC_SYSTEM_FUNCTIONS);
    end else begin
      ok_next = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Cycle sequencing
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= LAD_IDLE;
    end else begin
      unique case (state_reg)
        LAD_IDLE: begin
          if (start) begin
            state_reg <= ok_next ? LAD_WAIT : LAD_DONE;
          end
        end
        LAD_WAIT: begin
          if (dev_ready_i) begin
            state_reg <= LAD_DONE;
          end
        end
        LAD_DONE: begin
          if (!as_i) begin
            state_reg <= LAD_IDLE;
          end
        end
        default: state_reg <= LAD_IDLE;
      endcase
    end
  end

  // Device strobes held from the accepted cycle until the device is ready.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dev_sel_o <= '0;
      floppy_reg_o <= '0;
      serial_reg_o <= '0;
      dev_addr_o <= '0;
      dev_rd_o <= 1'b0;
      dev_wr_o <= 1'b0;
    end else if (start && ok_next) begin
      dev_sel_o <= sel_next;
      floppy_reg_o <= freg_next;
      serial_reg_o <= sreg_next;
      dev_addr_o <= addr_i;
      dev_rd_o <= rd_i;
      dev_wr_o <= !rd_i;
    end else if (state_reg == LAD_WAIT && dev_ready_i) begin
      dev_sel_o <= '0;
      floppy_reg_o <= '0;
      serial_reg_o <= '0;
      dev_rd_o <= 1'b0;
      dev_wr_o <= 1'b0;
    end
  end

  // One-cycle acknowledge; a refused cycle gets the error code.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_reg <= ACK_IDLE;
      err_reg <= 1'b0;
    end else if (start && !ok_next) begin
      ack_reg <= ACK_ERR;
      err_reg <= 1'b1;
    end else if (state_reg == LAD_WAIT && dev_ready_i) begin
      ack_reg <= ack_for(size_i);
      err_reg <= 1'b0;
    end else begin
      ack_reg <= ACK_IDLE;
      err_reg <= 1'b0;
    end
  end

  assign ack_o = ack_reg;
  assign err_o = err_reg;

endmodule // lad_local_io_address_decoder

`default_nettype wire

// *** lad_pkg.sv ***
/*
  Constants for the local I/O address decoder: region bounds, register
  addresses, access sizes and acknowledge codes.
  Assumes a 32-bit physical address and the usual slave size encoding.
*/
`default_nettype none

package lad_pkg;

  // ----------------------------------------------------------------------
  // Bus sizes and acknowledges
  // ----------------------------------------------------------------------
  localparam logic [2:0] SIZE_WORD = 3'h0;
  localparam logic [2:0] SIZE_BYTE = 3'h1;
  localparam logic [2:0] SIZE_HALF = 3'h2;
  localparam logic [1:0] ACK_IDLE = 2'h0;
  localparam logic [1:0] ACK_BYTE = 2'h1;
  localparam logic [1:0] ACK_HALF = 2'h2;
  localparam logic [1:0] ACK_WORD = 2'h3;
  localparam logic [1:0] ACK_ERR = 2'h3;

  // ----------------------------------------------------------------------
  // Clock rates of the slave interface
  // ----------------------------------------------------------------------
  localparam int SLOW_CLK_KHZ = 21250;
  localparam int FAST_CLK_KHZ = 22000;

  // ----------------------------------------------------------------------
  // Region bounds
  // ----------------------------------------------------------------------
  localparam logic [31:0] FLASH_LO = 32'h7000_0000;
  localparam logic [31:0] FLASH_HI = 32'h70ff_ffff;
  localparam logic [31:0] SERIAL_LO = 32'h7100_0000;
  localparam logic [31:0] SERIAL_HI = 32'h711f_ffff;
  localparam logic [31:0] CLKNV_LO = 32'h7120_0000;
  localparam logic [31:0] CLKNV_HI = 32'h712f_ffff;
  localparam logic [31:0] PROG_LO = 32'h7130_0000;
  localparam logic [31:0] PROG_HI = 32'h7137_ffff;
  localparam logic [31:0] EXTRA_LO = 32'h7138_0000;
  localparam logic [31:0] EXTRA_HI = 32'h713f_ffff;
  localparam logic [31:0] FLOPPY_LO = 32'h7140_0000;
  localparam logic [31:0] FLOPPY_HI = 32'h714f_ffff;
  localparam logic [31:0] RSVD_LO = 32'h7150_0000;
  localparam logic [31:0] RSVD_HI = 32'h7170_0000;
  localparam logic [31:0] CONFIG_ADDR = 32'h7180_0000;
  localparam logic [31:0] AUX_LO = 32'h7190_0000;
  localparam logic [31:0] AUX_HI = 32'h719f_ffff;

  // ----------------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------------
  localparam logic [31:0] POINTER_CTRL_PORT = 32'h7100_0000;
  localparam logic [31:0] POINTER_DATA_PORT = 32'h7100_0002;
  localparam logic [31:0] KEYS_CTRL_PORT = 32'h7100_0004;
  localparam logic [31:0] KEYS_DATA_PORT = 32'h7100_0006;
  localparam logic [31:0] SERIAL_TWO_CTRL = 32'h7110_0000;
  localparam logic [31:0] SERIAL_TWO_DATA = 32'h7110_0002;
  localparam logic [31:0] SERIAL_ONE_CTRL = 32'h7110_0004;
  localparam logic [31:0] SERIAL_ONE_DATA = 32'h7110_0006;
  localparam logic [31:0] FLOPPY_OUT_CTRL = 32'h7140_0002;
  localparam logic [31:0] FLOPPY_STATE_RATE = 32'h7140_0004;
  localparam logic [31:0] FLOPPY_DATA_QUEUE = 32'h7140_0005;
  localparam logic [31:0] FLOPPY_TEST_SELECT = 32'h7140_0006;
  localparam logic [31:0] FLOPPY_INPUT_CONFIG = 32'h7140_0007;
  localparam logic [31:0] MISC_SYSTEM_FUNCTIONS = 32'h7190_0000;
  localparam logic [31:0] SOFT_POWERDOWN_CTRL = 32'h7191_0000;

  // ----------------------------------------------------------------------
  // Device selects, one bit each
  // ----------------------------------------------------------------------
  localparam int SEL_W = 9;
  localparam int SEL_FLASH = 0;
  localparam int SEL_SERIAL = 1;
  localparam int SEL_CLKNV = 2;
  localparam int SEL_PROG = 3;
  localparam int SEL_EXTRA = 4;
  localparam int SEL_FLOPPY = 5;
  localparam int SEL_CONFIG = 6;
  localparam int SEL_AUX1 = 7;
  localparam int SEL_AUX2 = 8;

  // Floppy register strobes.
  localparam int FREG_W = 7;
  localparam int FREG_OUT_CTRL = 0;
  localparam int FREG_MAIN_STATE = 1;
  localparam int FREG_RATE_SELECT = 2;
  localparam int FREG_DATA_QUEUE = 3;
  localparam int FREG_INPUT_STATE = 4;
  localparam int FREG_CONFIG_CTRL = 5;
  localparam int FREG_TEST_SELECT = 6;

  // Serial-type port strobes.
  localparam int SREG_W = 8;

  typedef enum logic [1:0] {
    LAD_IDLE = 2'b00,
    LAD_WAIT = 2'b01,
    LAD_DONE = 2'b11
  } lad_state_e;

endpackage : lad_pkg

`default_nettype wire

// *** lad_checker.sv ***
/* Port checker for the address decoder.
   Assumes it is bound to the decoder top module. */
`timescale 1ns/1ns
`default_nettype none
module lad_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sel_i,
  input wire logic as_i,
  input wire logic [31:0] addr_i,
  input wire logic [2:0] size_i,
  input wire logic rd_i,
  input wire logic [1:0] ack_o,
  input wire logic err_o,
  input wire logic [lad_pkg::SEL_W-1:0] dev_sel_o,
  input wire logic [lad_pkg::FREG_W-1:0] floppy_reg_o,
  input wire logic [lad_pkg::SREG_W-1:0] serial_reg_o,
  input wire logic [31:0] dev_addr_o,
  input wire logic dev_rd_o,
  input wire logic dev_wr_o,
  input wire logic dev_ready_i
);
  import lad_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_take;
    $rose(sel_i && as_i);
  endsequence
  sequence s_done;
    (dev_rd_o | dev_wr_o) && dev_ready_i;
  endsequence
  property p_err_ack; err_o |-> ack_o == ACK_ERR; endproperty
  a_err_ack: assert property (p_err_ack) else $error("error without code");
  property p_err_quiet; err_o |-> dev_sel_o == '0 && !dev_rd_o && !dev_wr_o; endproperty
  a_err_quiet: assert property (p_err_quiet) else $error("error with select");
  property p_ack_pulse; ack_o != ACK_IDLE |=> ack_o == ACK_IDLE; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_byte_only; (dev_sel_o & 9'h1fa) != '0 |-> size_i == SIZE_BYTE; endproperty
  a_byte_only: assert property (p_byte_only) else $error("wide byte access");
  property p_flash_take;
    s_take ##0 (addr_i inside {[FLASH_LO:FLASH_HI]} && size_i == SIZE_WORD)
      |=> dev_sel_o[SEL_FLASH] && dev_addr_o == addr_i;
  endproperty
  a_flash_take: assert property (p_flash_take) else $error("flash not selected");
  property p_bad_serial;
    s_take ##0 (addr_i inside {[SERIAL_LO:SERIAL_HI]} && size_i != SIZE_BYTE) |=> err_o;
  endproperty
  a_bad_serial: assert property (p_bad_serial) else $error("wide serial accepted");
  property p_ready_ack;
    s_done |=> !dev_rd_o && !dev_wr_o && ack_o == ((size_i == SIZE_BYTE) ? ACK_BYTE :
      (size_i == SIZE_HALF) ? ACK_HALF : ACK_WORD);
  endproperty
  a_ready_ack: assert property (p_ready_ack) else $error("bad ack after ready");
  property p_floppy_dir;
    (floppy_reg_o[FREG_MAIN_STATE] || floppy_reg_o[FREG_INPUT_STATE]) |-> dev_rd_o && !dev_wr_o;
  endproperty
  a_floppy_dir: assert property (p_floppy_dir) else $error("floppy read direction");
  property p_floppy_wr;
    (floppy_reg_o[FREG_RATE_SELECT] || floppy_reg_o[FREG_CONFIG_CTRL]) |-> dev_wr_o && !dev_rd_o;
  endproperty
  a_floppy_wr: assert property (p_floppy_wr) else $error("floppy write direction");
  property p_rsvd; s_take ##0 addr_i inside {[RSVD_LO:RSVD_HI]} |=> err_o; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved accepted");
endmodule // lad_checker
`default_nettype wire

// *** lad_dev_model.sv ***
/* Local device model: raises ready a set number of cycles after a strobe.
   Assumes the decoder's registered read and write strobes. */
`timescale 1ns/1ns
`default_nettype none
module lad_dev_model (
  // Clock, reset and delay
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [1:0] dly_i,
  // Strobes and answer
  input wire logic dev_rd_i,
  input wire logic dev_wr_i,
  output logic dev_ready_o
);
  logic [1:0] cnt_reg;
  // Ready is a single pulse so each access finishes once.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg <= 2'h0;
      dev_ready_o <= 1'b0;
    end else if ((dev_rd_i | dev_wr_i) && !dev_ready_o && cnt_reg == dly_i) begin
      cnt_reg <= 2'h0;
      dev_ready_o <= 1'b1;
    end else begin
      cnt_reg <= ((dev_rd_i | dev_wr_i) && !dev_ready_o) ? cnt_reg + 2'h1 : 2'h0;
      dev_ready_o <= 1'b0;
    end
  end
endmodule // lad_dev_model
`default_nettype wire

// *** lad_local_io_address_decoder_tb_top.sv ***
/* Bench: table of decoder cycles, then register strobes and reset cases.
   Assumes the decoder, its package, the device model and the checker. */
`timescale 1ns/1ns
`default_nettype none
module lad_local_io_address_decoder_tb_top;
  import lad_pkg::*;
  typedef struct packed {logic [31:0] a; logic [2:0] s; logic [1:0] k; logic [8:0] d;} lad_row_s;
  logic clk_i, rst_i, sel_i, as_i, rd_i, err_o, dev_rd_o, dev_wr_o, dev_ready_i, ge;
  logic [31:0] addr_i, dev_addr_o, ga;
  logic [2:0] size_i;
  logic [1:0] ack_o, dly, gk, gd;
  logic [8:0] dev_sel_o, gs;
  logic [6:0] floppy_reg_o, gf;
  logic [7:0] serial_reg_o, gq;
  int n_errors = 0;
  int n_tests = 0;
  // The floppy test-mode address is never accessed.
  lad_row_s rows [16] = '{'{FLASH_LO, SIZE_WORD, ACK_WORD, 9'h001},
    '{FLASH_HI - 1, SIZE_HALF, ACK_HALF, 9'h001}, '{SERIAL_ONE_DATA, SIZE_BYTE, ACK_BYTE, 9'h002},
    '{SERIAL_LO, SIZE_HALF, ACK_ERR, 9'h0}, '{CLKNV_LO, SIZE_WORD, ACK_WORD, 9'h004},
    '{PROG_HI, SIZE_BYTE, ACK_BYTE, 9'h008}, '{PROG_LO, SIZE_WORD, ACK_ERR, 9'h0},
    '{EXTRA_LO, SIZE_BYTE, ACK_BYTE, 9'h010}, '{FLOPPY_DATA_QUEUE, SIZE_BYTE, ACK_BYTE, 9'h020},
    '{FLOPPY_OUT_CTRL, SIZE_WORD, ACK_ERR, 9'h0}, '{RSVD_LO, SIZE_BYTE, ACK_ERR, 9'h0},
    '{CONFIG_ADDR, SIZE_BYTE, ACK_BYTE, 9'h040}, '{AUX_LO, SIZE_BYTE, ACK_BYTE, 9'h080},
    '{SOFT_POWERDOWN_CTRL, SIZE_BYTE, ACK_BYTE, 9'h100},
    '{SOFT_POWERDOWN_CTRL, SIZE_HALF, ACK_ERR, 9'h0}, '{FLASH_LO, 3'h3, ACK_ERR, 9'h0}};
  logic [31:0] sa [8] = '{POINTER_CTRL_PORT, POINTER_DATA_PORT, KEYS_CTRL_PORT, KEYS_DATA_PORT,
    SERIAL_TWO_CTRL, SERIAL_TWO_DATA, SERIAL_ONE_CTRL, SERIAL_ONE_DATA};
  int fr [4] = '{FREG_MAIN_STATE, FREG_RATE_SELECT, FREG_INPUT_STATE, FREG_CONFIG_CTRL};
  lad_local_io_address_decoder DUT (.clk_i(clk_i), .rst_i(rst_i), .sel_i(sel_i), .as_i(as_i),
    .addr_i(addr_i), .size_i(size_i), .rd_i(rd_i), .ack_o(ack_o), .err_o(err_o),
    .dev_sel_o(dev_sel_o), .floppy_reg_o(floppy_reg_o), .serial_reg_o(serial_reg_o),
    .dev_addr_o(dev_addr_o), .dev_rd_o(dev_rd_o), .dev_wr_o(dev_wr_o), .dev_ready_i(dev_ready_i));
  lad_dev_model u_dev (.clk_i(clk_i), .rst_i(rst_i), .dly_i(dly), .dev_rd_i(dev_rd_o),
    .dev_wr_i(dev_wr_o), .dev_ready_o(dev_ready_i));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic run(input logic [31:0] a, input logic [2:0] s, input logic r);
    {gs, gf, gq, gk, ge, ga, gd} = '0;
    {sel_i, as_i, addr_i, size_i, rd_i} = {2'b11, a, s, r};
    for (int i = 0; i < 20 && gk === 2'h0; i++) begin
      @(posedge clk_i);
      #1;
      gs |= dev_sel_o;
      gf |= floppy_reg_o;
      gq |= serial_reg_o;
      if (dev_rd_o | dev_wr_o) begin
        ga = dev_addr_o;
        gd = {dev_rd_o, dev_wr_o};
      end
      gk = ack_o;
      ge = err_o;
    end
    if (gk === 2'h0) begin
      n_errors++;
      end_sim();
    end
    {sel_i, as_i} = 2'b00;
    @(posedge clk_i);
    #1;
  endtask
  initial begin
    {rst_i, sel_i, as_i, addr_i, size_i, rd_i, dly} = {3'b100, 32'h0, 3'h0, 1'b0, 2'h0};
    repeat (3) @(posedge clk_i);
    #1;
    chk("reset", 32'({ack_o, err_o, dev_sel_o, floppy_reg_o, dev_rd_o, dev_wr_o}), 32'h0);
    rst_i = 1'b0;
    for (int i = 0; i < 16; i++) begin
      dly = 2'(i % 3);
      run(rows[i].a, rows[i].s, 1'b1);
      chk("ack", 32'(gk), 32'(rows[i].k));
      chk("err", 32'(ge), 32'(rows[i].d == 9'h0));
      chk("sel", 32'(gs), 32'(rows[i].d));
      if (rows[i].d != 9'h0) chk("addr", ga, rows[i].a);
    end
    $display("table done");
    for (int i = 0; i < 8; i++) begin
      run(sa[i], SIZE_BYTE, i[0]);
      chk("serial", 32'(gq), 32'(1) << i);
      chk("serial_dir", 32'(gd), 32'({i[0], ~i[0]}));
    end
    for (int i = 0; i < 4; i++) begin
      run(i < 2 ? FLOPPY_STATE_RATE : FLOPPY_INPUT_CONFIG, SIZE_BYTE, ~i[0]);
      chk("floppy", 32'(gf), 32'(1) << fr[i]);
      chk("floppy_dir", 32'(gd), 32'({~i[0], i[0]}));
    end
    $display("register strobes done");
    {sel_i, as_i, addr_i, size_i, rd_i, dly} = {2'b11, FLASH_LO, SIZE_WORD, 1'b1, 2'h3};
    @(posedge clk_i);
    #1;
    rst_i = 1'b1;
    {sel_i, as_i} = 2'b00;
    #1;
    chk("midreset", 32'({ack_o, err_o, dev_sel_o, dev_rd_o, dev_wr_o}), 32'h0);
    @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    run(CLKNV_LO, SIZE_HALF, 1'b0);
    chk("after", 32'(gk), 32'(ACK_HALF));
    $display("reset done");
    end_sim();
  end
endmodule // lad_local_io_address_decoder_tb_top
bind lad_local_io_address_decoder lad_checker u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .sel_i(sel_i), .as_i(as_i), .addr_i(addr_i), .size_i(size_i), .rd_i(rd_i), .ack_o(ack_o),
  .err_o(err_o), .dev_sel_o(dev_sel_o), .floppy_reg_o(floppy_reg_o),
  .serial_reg_o(serial_reg_o), .dev_addr_o(dev_addr_o), .dev_rd_o(dev_rd_o),
  .dev_wr_o(dev_wr_o), .dev_ready_i(dev_ready_i));
`default_nettype wire
